// ===== design/perf_state_regs.vh
// register indices, field positions and reset values of the p-state block
// assumes inclusion by bare name from the design files
`ifndef PERF_STATE_REGS_VH
`define PERF_STATE_REGS_VH

`define ADDR_FIXED_RATE_COUNT   10'h0E7
`define ADDR_ACTUAL_RATE_COUNT  10'h0E8
`define ADDR_PERF_TARGET_CTL    10'h199
`define ADDR_PERF_CUR_STATUS    10'h198
`define ADDR_MISC_FEATURE_EN    10'h1A0
`define ADDR_CAP_LEAF_BASIC     10'h301
`define ADDR_CAP_LEAF_POWER     10'h306

`define MISC_PSTATE_EN_BIT      16
`define CAP_PSTATE_CTL_BIT      7
`define CAP_FEEDBACK_BIT        0
`define OP_POINT_W              16
`define COUNT_W                 64
`define COUNT_ZERO              64'h0000000000000000
`define COUNT_ONE               64'h0000000000000001
`define COUNT_MAX               64'hFFFFFFFFFFFFFFFF
`define DATA_ZERO               64'h0000000000000000

`endif

// ===== design/op_point_stepper.v
// operating-point stepper: one transition at a time, with a pending slot
// assumes a settle count of clk_en-enabled core_clk cycles per transition
`timescale 1ns/10ps
`default_nettype none

module op_point_stepper
#(
  parameter                  SETTLE_CYCLES = 16,
  parameter [15:0]           INIT_POINT    = 16'h0000
)
(
  input  wire                core_clk,
  input  wire                reset,
  input  wire                clk_en,
  input  wire                enable,
  input  wire                req_valid,
  input  wire [15:0]         req_point,
  output reg  [15:0]         cur_point_q,
  output wire                busy
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_MOVE = 2'b01;

  reg  [1:0]  state_q;
  reg  [15:0] target_q;
  reg  [15:0] pend_point_q;
  reg         pend_valid_q;
  reg  [15:0] wait_q;

  assign busy = (state_q == ST_MOVE);

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q      <= ST_IDLE;
      target_q     <= INIT_POINT;
      pend_point_q <= INIT_POINT;
      pend_valid_q <= 1'b0;
      wait_q       <= 16'h0000;
      cur_point_q  <= INIT_POINT;
    end
    else if (clk_en)
    begin
      if (req_valid)
      begin
        pend_point_q <= req_point;
        pend_valid_q <= 1'b1;
      end
      case (state_q)
        ST_IDLE:
        begin
          if (pend_valid_q && enable && !req_valid)
          begin
            target_q     <= pend_point_q;
            pend_valid_q <= 1'b0;
            wait_q       <= SETTLE_CYCLES[15:0];
            state_q      <= ST_MOVE;
          end
        end
        ST_MOVE:
        begin
          if (wait_q > 16'h0001)
            wait_q <= wait_q - 16'h0001;
          else
          begin
            cur_point_q <= target_q;
            state_q     <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // op_point_stepper

`default_nettype wire

// ===== design/perf_state_ctl.v
// p-state control and feedback counters for one logical processor
// assumes a model-register access port and per-cycle increment strobes
//
// Overview of operation
// - transitions only with enable bit 16; reset clears
// - capability bit 07 reports p-state control
// - target write starts a transition
// - write during transition queued, applied afterwards
// - target reads return last in-range request
// - status shows point in force
// - operating-point encoding is a parameter
// - discrete step, no sleep, no hold-off
// - power leaf bit 0 reports counters
// - fixed counter runs at boot-set reference rate
// - actual counter follows delivered performance
// - own counter pair, counting only in C0
// - either overflow clears both, counting continues
// - both counters full 64 bits
// - each counter written independently
`timescale 1ns/10ps
`default_nettype none

`include "perf_state_regs.vh"

module perf_state_ctl
#(
  parameter                  SETTLE_CYCLES = 16,
  parameter [15:0]           INIT_POINT    = 16'h0000,
  parameter [15:0]           POINT_MIN     = 16'h0000,
  parameter [15:0]           POINT_MAX     = 16'hFFFF
)
(
  input  wire                core_clk,
  input  wire                reset,
  input  wire                clk_en,
  input  wire                reg_wr,
  input  wire                reg_rd,
  input  wire [9:0]          reg_addr,
  input  wire [63:0]         reg_wdata,
  output reg  [63:0]         reg_rdata,
  output reg                 reg_ack,
  output reg                 reg_err,
  input  wire                in_c0,
  input  wire                ref_tick,
  input  wire                perf_tick,
  output wire [15:0]         op_point,
  output wire                transition_busy,
  output wire                pstate_enabled
);

  reg  [63:0] misc_q;
  reg  [15:0] target_q;
  reg  [63:0] fixed_q;
  reg  [63:0] actual_q;
  reg  [63:0] fixed_d;
  reg  [63:0] actual_d;
  reg         wrap_fixed;
  reg         wrap_actual;
  wire [15:0] cur_point;
  wire        target_wr;
  wire        in_range;

  assign in_range  = (reg_wdata[15:0] >= POINT_MIN) && (reg_wdata[15:0] <= POINT_MAX);
  assign target_wr = reg_wr && (reg_addr == `ADDR_PERF_TARGET_CTL) && in_range;
  assign pstate_enabled  = misc_q[`MISC_PSTATE_EN_BIT];
  assign op_point        = cur_point;

  op_point_stepper
  #(
    .SETTLE_CYCLES (SETTLE_CYCLES),
    .INIT_POINT    (INIT_POINT)
  )
  u_stepper
  (
    .core_clk      (core_clk),
    .reset         (reset),
    .clk_en        (clk_en),
    .enable        (pstate_enabled),
    .req_valid     (target_wr),
    .req_point     (reg_wdata[15:0]),
    .cur_point_q   (cur_point),
    .busy          (transition_busy)
  );

  // counter next values
  always @*
  begin
    fixed_d     = fixed_q;
    actual_d    = actual_q;
    wrap_fixed  = 1'b0;
    wrap_actual = 1'b0;
    if (in_c0)
    begin
      if (ref_tick)
      begin
        wrap_fixed = (fixed_q == `COUNT_MAX);
        fixed_d    = fixed_q + `COUNT_ONE;
      end
      if (perf_tick)
      begin
        wrap_actual = (actual_q == `COUNT_MAX);
        actual_d    = actual_q + `COUNT_ONE;
      end
    end
    if (wrap_fixed || wrap_actual)
    begin
      fixed_d  = `COUNT_ZERO;
      actual_d = `COUNT_ZERO;
    end
    if (reg_wr && (reg_addr == `ADDR_FIXED_RATE_COUNT))
      fixed_d = reg_wdata;
    if (reg_wr && (reg_addr == `ADDR_ACTUAL_RATE_COUNT))
      actual_d = reg_wdata;
  end

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      fixed_q  <= `COUNT_ZERO;
      actual_q <= `COUNT_ZERO;
      misc_q   <= `DATA_ZERO;
      target_q <= INIT_POINT;
    end
    else if (clk_en)
    begin
      fixed_q  <= fixed_d;
      actual_q <= actual_d;
      if (reg_wr && (reg_addr == `ADDR_MISC_FEATURE_EN))
        misc_q <= reg_wdata;
      if (target_wr)
        target_q <= reg_wdata[15:0];
    end
  end

  // read port and unmapped-address answer
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      reg_rdata <= `DATA_ZERO;
      reg_ack   <= 1'b0;
      reg_err   <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_ack   <= reg_rd || reg_wr;
      reg_err   <= 1'b0;
      reg_rdata <= `DATA_ZERO;
      if (reg_rd)
      begin
        if (reg_addr == `ADDR_FIXED_RATE_COUNT)
          reg_rdata <= fixed_q;
        else if (reg_addr == `ADDR_ACTUAL_RATE_COUNT)
          reg_rdata <= actual_q;
        else if (reg_addr == `ADDR_PERF_TARGET_CTL)
          reg_rdata <= {48'h000000000000, target_q};
        else if (reg_addr == `ADDR_PERF_CUR_STATUS)
          reg_rdata <= {48'h000000000000, cur_point};
        else if (reg_addr == `ADDR_MISC_FEATURE_EN)
          reg_rdata <= misc_q;
        else if (reg_addr == `ADDR_CAP_LEAF_BASIC)
          reg_rdata <= `COUNT_ONE << `CAP_PSTATE_CTL_BIT;
        else if (reg_addr == `ADDR_CAP_LEAF_POWER)
          reg_rdata <= `COUNT_ONE << `CAP_FEEDBACK_BIT;
        else
          reg_err <= 1'b1;
      end
      else if (reg_wr)
      begin
        if ((reg_addr != `ADDR_FIXED_RATE_COUNT) && (reg_addr != `ADDR_ACTUAL_RATE_COUNT)
            && (reg_addr != `ADDR_PERF_TARGET_CTL) && (reg_addr != `ADDR_MISC_FEATURE_EN))
          reg_err <= 1'b1;
        else if ((reg_addr == `ADDR_PERF_TARGET_CTL) && !in_range)
          reg_err <= 1'b1;
      end
    end
  end

endmodule // perf_state_ctl

`default_nettype wire

// ===== verif/perf_state_ctl_chk.sv
// port checker for the p-state block, bound to perf_state_ctl
// assumes the register indices of perf_state_regs.vh
`timescale 1ns/10ps
`default_nettype none
`include "perf_state_regs.vh"
module perf_state_ctl_chk (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [9:0]  reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic [63:0] reg_rdata,
  input wire logic        reg_ack,
  input wire logic        reg_err,
  input wire logic        in_c0,
  input wire logic        ref_tick,
  input wire logic        perf_tick,
  input wire logic [15:0] op_point,
  input wire logic        transition_busy,
  input wire logic        pstate_enabled
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire wr_only = clk_en && reg_wr && !reg_rd;
  wire en_hit  = reg_wr && reg_addr == `ADDR_MISC_FEATURE_EN;
  ack_after_req_a: assert property (clk_en && (reg_rd || reg_wr) |=> reg_ack)
    else $error("request without ack");
  ack_idle_a: assert property (clk_en && !reg_rd && !reg_wr |=> !reg_ack && !reg_err)
    else $error("ack without request");
  rdata_idle_a: assert property (clk_en && !reg_rd |=> reg_rdata == `DATA_ZERO)
    else $error("read data without read");
  enable_write_a: assert property (wr_only && en_hit |=> pstate_enabled == $past(reg_wdata[16]))
    else $error("enable bit not taken");
  enable_hold_a: assert property (clk_en && !en_hit |=> $stable(pstate_enabled))
    else $error("enable bit moved");
  busy_start_a: assert property (wr_only && reg_addr == `ADDR_PERF_TARGET_CTL && pstate_enabled
    && !transition_busy && reg_wdata[63:16] == 48'h0 |=> ##1 transition_busy)
    else $error("target write started nothing");
  busy_enable_a: assert property ($rose(transition_busy) |-> $past(pstate_enabled))
    else $error("transition while disabled");
  busy_min_a: assert property ($rose(transition_busy) |-> transition_busy[*2])
    else $error("transition too short");
  point_change_a: assert property ($changed(op_point) |-> $past(transition_busy))
    else $error("point moved outside transition");
  status_ro_a: assert property (wr_only && reg_addr == `ADDR_PERF_CUR_STATUS |=> reg_err)
    else $error("status write accepted");
endmodule // perf_state_ctl_chk
bind perf_state_ctl perf_state_ctl_chk u_chk (.core_clk, .reset, .clk_en, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .reg_err, .in_c0, .ref_tick, .perf_tick,
  .op_point, .transition_busy, .pstate_enabled);
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for perf_state_ctl with a counter model
// assumes a settle count of 6 and initial point 0
`timescale 1ns/10ps
`default_nettype none
`include "perf_state_regs.vh"
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
  logic        core_clk, reset, clk_en, reg_wr, reg_rd, in_c0, ref_tick, perf_tick;
  logic        reg_ack, reg_err, transition_busy, pstate_enabled, eq;
  logic [9:0]  reg_addr;
  logic [63:0] reg_wdata, reg_rdata, rq, fix_m, act_m;
  logic [64:0] nf, na;
  logic [15:0] op_point;
  logic [31:0] seed;
  int          n_fail, total_checks, cyc;
  perf_state_ctl #(.SETTLE_CYCLES(6), .POINT_MAX(16'hF000)) u_perf_state_ctl (.core_clk, .reset,
    .clk_en, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .reg_err, .in_c0, .ref_tick,
    .perf_tick, .op_point, .transition_busy, .pstate_enabled);
  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task stop_test;
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // counter model: write beats increment, overflow clears both
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      stop_test;
    end
    nf = fix_m + (clk_en && in_c0 && ref_tick);
    na = act_m + (clk_en && in_c0 && perf_tick);
    fix_m <= reset ? 64'h0 : (nf[64] | na[64]) ? 64'h0 : nf[63:0];
    act_m <= reset ? 64'h0 : (nf[64] | na[64]) ? 64'h0 : na[63:0];
    if (!reset && clk_en && reg_wr && reg_addr == `ADDR_FIXED_RATE_COUNT)
      fix_m <= reg_wdata;
    if (!reset && clk_en && reg_wr && reg_addr == `ADDR_ACTUAL_RATE_COUNT)
      act_m <= reg_wdata;
  end
  task acc(input logic w, input logic [9:0] a, input logic [63:0] d);
    @(negedge core_clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    if (!w)
    begin
      ref_tick = 1'b0;
      perf_tick = 1'b0;
    end
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rq = reg_rdata;
    eq = reg_err;
    `CHK("ack", 1'b1, reg_ack)
  endtask
  task run(input int n, input logic m);
    repeat (n)
    begin
      @(negedge core_clk);
      seed = lfsr(seed);
      clk_en = seed[9] | seed[11];
      in_c0 = seed[0] & m;
      ref_tick = seed[2];
      perf_tick = seed[5];
    end
    @(negedge core_clk);
    clk_en = 1'b1;
  endtask
  task chkcnt;
    acc(1'b0, `ADDR_FIXED_RATE_COUNT, 64'h0);
    `CHK("fixed", fix_m, rq)
    acc(1'b0, `ADDR_ACTUAL_RATE_COUNT, 64'h0);
    `CHK("actual", act_m, rq)
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial
  begin
    {reset, clk_en, reg_wr, reg_rd, in_c0, ref_tick, perf_tick} = 7'b1100000;
    reg_addr = 10'h000;
    reg_wdata = 64'h0;
    seed = 32'h30EC;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    acc(1'b0, `ADDR_MISC_FEATURE_EN, 64'h0);
    `CHK("misc", 64'h0, rq)
    acc(1'b0, `ADDR_PERF_CUR_STATUS, 64'h0);
    `CHK("status", 16'h0000, rq[15:0])
    chkcnt;
    acc(1'b0, `ADDR_CAP_LEAF_BASIC, 64'h0);
    `CHK("cap", 1'b1, rq[`CAP_PSTATE_CTL_BIT])
    acc(1'b0, `ADDR_CAP_LEAF_POWER, 64'h0);
    `CHK("leaf", 1'b1, rq[`CAP_FEEDBACK_BIT])
    acc(1'b0, 10'h000, 64'h0);
    `CHK("unmapped", 1'b1, eq)
    acc(1'b1, `ADDR_PERF_CUR_STATUS, 64'h0);
    `CHK("ro", 1'b1, eq)
    run(200, 1'b1);
    chkcnt;
    run(50, 1'b0);
    chkcnt;
    run(5, 1'b1);
    acc(1'b1, `ADDR_FIXED_RATE_COUNT, {seed, lfsr(seed)});
    chkcnt;
    for (int i = 0; i < 2; i++)
    begin
      acc(1'b1, i ? `ADDR_ACTUAL_RATE_COUNT : `ADDR_FIXED_RATE_COUNT, `COUNT_MAX);
      run(30, 1'b1);
      chkcnt;
    end
    acc(1'b1, `ADDR_FIXED_RATE_COUNT, 64'h0);
    acc(1'b1, `ADDR_ACTUAL_RATE_COUNT, 64'h0);
    chkcnt;
    acc(1'b1, `ADDR_PERF_TARGET_CTL, 64'hFFFF);
    `CHK("range", 1'b1, eq)
    acc(1'b0, `ADDR_PERF_TARGET_CTL, 64'h0);
    `CHK("refused", 16'h0000, rq[15:0])
    acc(1'b1, `ADDR_PERF_TARGET_CTL, 64'h1234);
    repeat (20) @(negedge core_clk);
    acc(1'b0, `ADDR_PERF_CUR_STATUS, 64'h0);
    `CHK("status", 16'h0000, rq[15:0])
    acc(1'b1, `ADDR_MISC_FEATURE_EN, 64'h10000);
    acc(1'b1, `ADDR_PERF_TARGET_CTL, 64'h00A5);
    acc(1'b0, `ADDR_PERF_TARGET_CTL, 64'h0);
    acc(1'b1, `ADDR_PERF_TARGET_CTL, 64'h5A3C);
    acc(1'b0, `ADDR_PERF_TARGET_CTL, 64'h0);
    `CHK("target", 16'h5A3C, rq[15:0])
    repeat (40) @(negedge core_clk);
    acc(1'b0, `ADDR_PERF_CUR_STATUS, 64'h0);
    `CHK("status", 16'h5A3C, rq[15:0])
    `CHK("point", 16'h5A3C, op_point)
    stop_test;
  end
endmodule // testbench
`default_nettype wire
